// [verification/dsp_external_bus_reset_tb.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Bench for the external bus sequencer and its reset pin
module dsp_external_bus_reset_tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic resetPin_n = 1'b0;
    logic opValid = 1'b0;
    logic [1:0] opKind = 2'h0;
    logic [2:0] opPort = 3'h0;
    logic [15:0] opData = 16'h0000;
    logic [15:0] opAddr = 16'h0000;
    logic opReady, instrValid, portInValid, dataOutEn_b;
    logic fetchStrobe_n, dataReadStrobe_n, portReadStrobe_n, portWriteStrobe_n;
    logic tableWriteStrobe_n;
    logic [15:0] instrWord, portInWord, progCounter, addrLines, dataIn, dataOut;
    logic [4:0] strobes;
    logic [15:0] expPc = 16'h0000;
    logic [15:0] expInstr[$];
    logic [15:0] expPortIn[$];
    logic [31:0] expWrite[$];
    int mismatches = 0;
    int check_count = 0;
    int seed = 266;
    bit monOn = 1'b0;

    assign strobes = {fetchStrobe_n, dataReadStrobe_n, portReadStrobe_n,
        portWriteStrobe_n, tableWriteStrobe_n};

    ext_bus_ctrl dut (.clk_sys(clk_sys), .rst_b(rst_b), .reset_in_n(resetPin_n),
        .opValid(opValid), .opKind(opKind), .opPort(opPort), .opData(opData),
        .opAddr(opAddr), .opReady(opReady), .instrWord(instrWord), .instrValid(instrValid),
        .portInWord(portInWord), .portInValid(portInValid), .progCounter(progCounter),
        .addrLines(addrLines), .dataIn(dataIn), .dataOut(dataOut), .dataOutEn_b(dataOutEn_b),
        .fetchStrobe_n(fetchStrobe_n), .dataReadStrobe_n(dataReadStrobe_n),
        .portReadStrobe_n(portReadStrobe_n), .portWriteStrobe_n(portWriteStrobe_n),
        .tableWriteStrobe_n(tableWriteStrobe_n));

    ext_bus_partner farSide (.clk_sys(clk_sys), .addrLines(addrLines),
        .fetchStrobe_n(fetchStrobe_n), .portReadStrobe_n(portReadStrobe_n),
        .dataOut(dataOut), .dataOutEn_b(dataOutEn_b), .dataIn(dataIn));

    // ============================================================
    // Clock, helpers and verdict
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [15:0] memWord(input logic [15:0] a);
        return a ^ 16'hA5C3;
    endfunction

    function automatic logic [15:0] portWord(input logic [2:0] p);
        return {10'h000, p, p} ^ 16'h3C5A;
    endfunction

    task automatic checkThat(input logic ok, input string what);
        check_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ============================================================
    // Cycle monitor; mid-cycle, once the registered outputs have settled
    always @(negedge clk_sys) begin
        if (monOn) begin
            checkThat($countones(~strobes[4:3]) + $countones(~strobes[1:0]) <= 1, "overlap");
            checkThat(strobes[2] || strobes === 5'b10011, "port read not alone");
            checkThat((strobes[2] && strobes[1]) || addrLines[15:3] === 13'h0000, "upper");
            checkThat(^addrLines !== 1'bx, "address floats");
            checkThat(dataOutEn_b === (strobes[1] & strobes[0]), "data drive");
            if (instrValid === 1'b1) begin
                checkThat(expInstr.size() > 0 && instrWord === expInstr.pop_front(), "instr");
            end
            if (portInValid === 1'b1) begin
                checkThat(expPortIn.size() > 0 && portInWord === expPortIn.pop_front(), "in");
            end
            if (strobes[1:0] !== 2'b11) begin
                checkThat(expWrite.size() > 0 && {addrLines, dataOut} === expWrite.pop_front(),
                    "write");
            end
        end
    end

    // Pin reset; model state cleared since writes cut by reset are void
    task automatic pinReset(input int hold);
        int n;
        monOn = 1'b0;
        resetPin_n = 1'b0;
        repeat (hold) @(negedge clk_sys);
        checkThat(strobes === 5'b11111 && dataOutEn_b === 1'b1, "reset strobes");
        checkThat(addrLines === 16'h0000 && progCounter === 16'h0000, "reset addr");
        resetPin_n = 1'b1;
        n = 0;
        while (opReady !== 1'b1 && n < 10) begin
            @(negedge clk_sys);
            n++;
        end
        checkThat(n >= 3 && n <= 5, "resume latency");
        expPc = 16'h0000;
        expInstr.delete();
        expPortIn.delete();
        expWrite.delete();
        monOn = 1'b1;
    endtask

    // One request, held until taken, then its bus cycles walked
    task automatic doOp(input logic [1:0] k, input logic [2:0] p, input logic [15:0] d,
            input logic [15:0] a);
        int n;
        n = 0;
        opValid = 1'b1;
        opKind = k;
        opPort = p;
        opData = d;
        opAddr = a;
        while (opReady !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        // Queued before the strobe cycle so the monitor never sees it first
        if (k == 2'h2) begin
            expWrite.push_back({13'h0000, p, d});
        end
        @(negedge clk_sys);
        opValid = 1'b0;
        if (k == 2'h1) begin
            checkThat(strobes === 5'b10011 && addrLines === {13'h0000, p}, "in cycle");
            expPortIn.push_back(portWord(p));
        end else if (k == 2'h2) begin
            checkThat(strobes === 5'b11101 && addrLines === {13'h0000, p}, "out cycle");
        end else begin
            checkThat(strobes === 5'b01111 && addrLines === expPc, "prefetch");
            if (k == 2'h3) begin
                expWrite.push_back({a, d});
                @(negedge clk_sys);
                checkThat(strobes === 5'b11110 && addrLines === a, "table cycle");
                @(negedge clk_sys);
                checkThat(strobes === 5'b01111 && addrLines === expPc, "next fetch");
            end
            expInstr.push_back(memWord(expPc));
            expPc++;
        end
    endtask

    // Every op kind first, then random kinds with gaps of zero to two cycles
    task automatic traffic(input int count);
        for (int i = 0; i < count; i++) begin
            doOp(i < 8 ? 2'(i) : 2'($random(seed)), 3'($random(seed)), 16'($random(seed)),
                16'($random(seed)));
            repeat ($unsigned($random(seed)) % 3) @(negedge clk_sys);
        end
        repeat (8) @(negedge clk_sys);
        checkThat(expInstr.size() + expPortIn.size() + expWrite.size() == 0, "lost");
    endtask

    // ============================================================
    // Main sequence, including a pin reset that falls during a table write's dummy prefetch
    initial begin
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        pinReset(5);
        traffic(60);
        opValid = 1'b1;
        opKind = 2'h3;
        @(negedge clk_sys);
        opValid = 1'b0;
        checkThat(strobes === 5'b01111, "dummy before abort");
        pinReset($unsigned($random(seed)) % 2 + 5);
        traffic(20);
        wrap_up();
    end

    // Watchdog, well past the expected run length
    initial begin
        #20000;
        mismatches++;
        $display("unexpected at %0t: run hung", $time);
        wrap_up();
    end
endmodule
`default_nettype wire

// [verification/ext_bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Program memory and port bank on the far side of the bus
module ext_bus_partner (
    input wire logic clk_sys, // System clock
    input wire logic [15:0] addrLines, // Address bus
    input wire logic fetchStrobe_n, // Fetch strobe
    input wire logic portReadStrobe_n, // Port input strobe
    input wire logic [15:0] dataOut, // Device drive value
    input wire logic dataOutEn_b, // Low while device drives
    output logic [15:0] dataIn // Resolved bus level
);
    logic [15:0] lastLevel = 16'h0000;

    // Answer only while strobed; a released bus drifts, no pull resistors
    always_comb begin
        if (!dataOutEn_b) begin
            dataIn = dataOut;
        end else if (!fetchStrobe_n) begin
            dataIn = addrLines ^ 16'hA5C3;
        end else if (!portReadStrobe_n) begin
            dataIn = {addrLines[12:0], addrLines[2:0]} ^ 16'h3C5A;
        end else begin
            dataIn = ~lastLevel;
        end
    end

    // Idle level flips each cycle so a late sample never matches
    always @(posedge clk_sys) begin
        lastLevel <= dataIn;
    end
endmodule
`default_nettype wire

// [verilog/ext_bus_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Reset forces strobes high, data bus released
// - Address and PC cleared during reset
// - Execution resumes one cycle after release
// - Reset pin synchronised; latency varies one cycle
// - At most one strobe low at once, except data read, which goes low with port read
// - Address lines always driven, never floating
// - Port number on three low address lines
// - Upper thirteen address lines low on ports
// - Data driven only during write strobes
// - Port read strobe only for port input
// - Port write strobe only for port output
// - Table write strobe only for table write
// - Fetch strobe low on every instruction fetch
module ext_bus_ctrl (
    input wire logic clk_sys, // System clock, 250 MHz
    input wire logic rst_b, // Power-on reset, async active low
    input wire logic reset_in_n, // Device reset pin, async
    input wire logic opValid, // Core requests a bus operation
    input wire logic [1:0] opKind, // Operation, an op_t code
    input wire logic [ext_bus_pkg::PORT_W-1:0] opPort, // Port number
    input wire logic [ext_bus_pkg::DATA_W-1:0] opData, // Word to write
    input wire logic [ext_bus_pkg::ADDR_W-1:0] opAddr, // Table write address
    output logic opReady, // Sequencer accepts a request
    output logic [ext_bus_pkg::DATA_W-1:0] instrWord, // Fetched word
    output logic instrValid, // Pulse, instrWord is new
    output logic [ext_bus_pkg::DATA_W-1:0] portInWord, // Port input word
    output logic portInValid, // Pulse, portInWord is new
    output logic [ext_bus_pkg::ADDR_W-1:0] progCounter, // Program counter
    output logic [ext_bus_pkg::ADDR_W-1:0] addrLines, // Address bus
    input wire logic [ext_bus_pkg::DATA_W-1:0] dataIn, // Data bus level
    output logic [ext_bus_pkg::DATA_W-1:0] dataOut, // Data bus drive value
    output logic dataOutEn_b, // Low while driving data bus
    output logic fetchStrobe_n, // Instruction fetch strobe
    output logic dataReadStrobe_n, // Data read strobe
    output logic portReadStrobe_n, // Port input strobe
    output logic portWriteStrobe_n, // Port output strobe
    output logic tableWriteStrobe_n // Table write strobe
);

    // ==========================================================
    // Reset pin synchroniser
    logic resetSyncA_q;
    logic resetSyncB_q;
    logic inReset;

    // Two flops; the pin edge may land anywhere in the period
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            resetSyncA_q <= 1'b0;
            resetSyncB_q <= 1'b0;
        end else begin
            resetSyncA_q <= reset_in_n;
            resetSyncB_q <= resetSyncA_q;
        end
    end
    assign inReset = !resetSyncB_q;

    // ==========================================================
    // Bus sequencer
    ext_bus_pkg::state_t stateQ, stateD;
    logic [ext_bus_pkg::ADDR_W-1:0] pc_q, pc_d, addr_q, addr_d, tblAddr_q, tblAddr_d;
    logic [ext_bus_pkg::PORT_W-1:0] port_q, port_d;
    logic [ext_bus_pkg::DATA_W-1:0] wData_q, wData_d, dOut_q, dOut_d;
    logic oeB_q, oeB_d, ready_q, ready_d;
    logic fetchN_q, fetchN_d, pReadN_q, pReadN_d, pWriteN_q, pWriteN_d, tWriteN_q, tWriteN_d;
    // Next state and outputs; outputs follow the state being entered
    always_comb begin
        stateD = stateQ;
        pc_d = pc_q;
        tblAddr_d = tblAddr_q;
        port_d = port_q;
        wData_d = wData_q;
        case (stateQ)
            ext_bus_pkg::ST_RESET: stateD = ext_bus_pkg::ST_RESUME;
            ext_bus_pkg::ST_RESUME: stateD = ext_bus_pkg::ST_IDLE;
            ext_bus_pkg::ST_IDLE: begin
                if (opValid) begin
                    port_d = opPort;
                    wData_d = opData;
                    tblAddr_d = opAddr;
                    case (ext_bus_pkg::op_t'(opKind))
                        ext_bus_pkg::OP_FETCH: stateD = ext_bus_pkg::ST_FETCH;
                        ext_bus_pkg::OP_PORT_IN: stateD = ext_bus_pkg::ST_PORT_IN;
                        ext_bus_pkg::OP_PORT_OUT: stateD = ext_bus_pkg::ST_PORT_OUT;
                        // Own prefetch came before; dummy prefetch next
                        ext_bus_pkg::OP_TABLE_WRITE: stateD = ext_bus_pkg::ST_DUMMY;
                        default: stateD = ext_bus_pkg::ST_IDLE;
                    endcase
                end
            end
            ext_bus_pkg::ST_FETCH: begin
                pc_d = pc_q + 16'h0001;
                stateD = ext_bus_pkg::ST_IDLE;
            end
            ext_bus_pkg::ST_DUMMY: stateD = ext_bus_pkg::ST_TABLE_WR;
            ext_bus_pkg::ST_TABLE_WR: stateD = ext_bus_pkg::ST_FETCH;
            default: stateD = ext_bus_pkg::ST_IDLE;
        endcase
        // Reset wins over any cycle, a write in flight included
        if (inReset) begin
            stateD = ext_bus_pkg::ST_RESET;
            pc_d = ext_bus_pkg::PC_RESET;
        end
        // Defaults give idle bus: strobes high, data released
        addr_d = addr_q; // Address held, never floated
        dOut_d = dOut_q;
        oeB_d = 1'b1;
        fetchN_d = 1'b1;
        pReadN_d = 1'b1;
        pWriteN_d = 1'b1;
        tWriteN_d = 1'b1;
        ready_d = 1'b0;
        // One case item per state keeps the strobes exclusive
        case (stateD)
            ext_bus_pkg::ST_RESET: addr_d = ext_bus_pkg::ADDR_RESET;
            ext_bus_pkg::ST_RESUME: addr_d = ext_bus_pkg::ADDR_RESET;
            ext_bus_pkg::ST_IDLE: ready_d = 1'b1;
            ext_bus_pkg::ST_FETCH, ext_bus_pkg::ST_DUMMY: begin
                addr_d = pc_d;
                fetchN_d = 1'b0;
            end
            ext_bus_pkg::ST_PORT_IN: begin
                addr_d = {ext_bus_pkg::UPPER_ZERO, port_d};
                pReadN_d = 1'b0;
            end
            ext_bus_pkg::ST_PORT_OUT: begin
                addr_d = {ext_bus_pkg::UPPER_ZERO, port_d};
                pWriteN_d = 1'b0;
                dOut_d = wData_d;
                oeB_d = 1'b0;
            end
            ext_bus_pkg::ST_TABLE_WR: begin
                addr_d = tblAddr_d;
                tWriteN_d = 1'b0;
                dOut_d = wData_d;
                oeB_d = 1'b0;
            end
            default: ready_d = 1'b0;
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stateQ <= ext_bus_pkg::ST_RESET;
            pc_q <= ext_bus_pkg::PC_RESET;
            addr_q <= ext_bus_pkg::ADDR_RESET;
            tblAddr_q <= ext_bus_pkg::ADDR_RESET;
            port_q <= ext_bus_pkg::PORT_RESET;
            wData_q <= ext_bus_pkg::DATA_RESET;
            dOut_q <= ext_bus_pkg::DATA_RESET;
            oeB_q <= 1'b1;
            ready_q <= 1'b0;
            fetchN_q <= 1'b1;
            pReadN_q <= 1'b1;
            pWriteN_q <= 1'b1;
            tWriteN_q <= 1'b1;
        end else begin
            stateQ <= stateD;
            pc_q <= pc_d;
            addr_q <= addr_d;
            tblAddr_q <= tblAddr_d;
            port_q <= port_d;
            wData_q <= wData_d;
            dOut_q <= dOut_d;
            oeB_q <= oeB_d;
            ready_q <= ready_d;
            fetchN_q <= fetchN_d;
            pReadN_q <= pReadN_d;
            pWriteN_q <= pWriteN_d;
            tWriteN_q <= tWriteN_d;
        end
    end

    // ==========================================================
    // Read data capture
    logic [ext_bus_pkg::DATA_W-1:0] dinA_q, dinA_d, dinB_q, dinB_d;
    logic [ext_bus_pkg::DATA_W-1:0] instr_q, instr_d, portIn_q, portIn_d;
    logic capF1_q, capF1_d, capF2_q, capF2_d, capP1_q, capP1_d, capP2_q, capP2_d;
    logic instrV_q, instrV_d, portV_q, portV_d;
    // Bus level passes two flops; a tag pipe follows it so data lines up
    always_comb begin
        dinA_d = dataIn;
        dinB_d = dinA_q;
        capF1_d = (stateQ == ext_bus_pkg::ST_FETCH);
        capP1_d = (stateQ == ext_bus_pkg::ST_PORT_IN);
        capF2_d = capF1_q;
        capP2_d = capP1_q;
        instr_d = capF2_q ? dinB_q : instr_q;
        portIn_d = capP2_q ? dinB_q : portIn_q;
        // Dummy prefetch words are dropped on purpose
        instrV_d = capF2_q;
        portV_d = capP2_q;
    end

    // Capture registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dinA_q <= ext_bus_pkg::DATA_RESET;
            dinB_q <= ext_bus_pkg::DATA_RESET;
            instr_q <= ext_bus_pkg::DATA_RESET;
            portIn_q <= ext_bus_pkg::DATA_RESET;
            capF1_q <= 1'b0;
            capF2_q <= 1'b0;
            capP1_q <= 1'b0;
            capP2_q <= 1'b0;
            instrV_q <= 1'b0;
            portV_q <= 1'b0;
        end else begin
            dinA_q <= dinA_d;
            dinB_q <= dinB_d;
            instr_q <= instr_d;
            portIn_q <= portIn_d;
            capF1_q <= capF1_d;
            capF2_q <= capF2_d;
            capP1_q <= capP1_d;
            capP2_q <= capP2_d;
            instrV_q <= instrV_d;
            portV_q <= portV_d;
        end
    end

    // ==========================================================
    // Outputs, each straight from a flop
    assign opReady = ready_q;
    assign instrWord = instr_q;
    assign instrValid = instrV_q;
    assign portInWord = portIn_q;
    assign portInValid = portV_q;
    assign progCounter = pc_q;
    assign addrLines = addr_q;
    assign dataOut = dOut_q;
    assign dataOutEn_b = oeB_q;
    assign fetchStrobe_n = fetchN_q;
    assign dataReadStrobe_n = pReadN_q; // Same flop as the port read strobe
    assign portReadStrobe_n = pReadN_q;
    assign portWriteStrobe_n = pWriteN_q;
    assign tableWriteStrobe_n = tWriteN_q;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    chk_reset_bus_idle: assert property (
        inReset |=> (fetchN_q && pReadN_q && pWriteN_q && tWriteN_q && dataReadStrobe_n && oeB_q))
        else $error("bus not idle during reset");
    chk_reset_addr_clear: assert property (
        inReset |=> (addr_q == 16'h0000 && pc_q == 16'h0000))
        else $error("address or pc not cleared in reset");
    chk_resume_one_cycle: assert property (
        $rose(resetSyncB_q) |=> !ready_q ##1 ready_q)
        else $error("resume not one cycle after release");
    chk_sync_entry_latency: assert property (
        $fell(reset_in_n) ##1 !reset_in_n ##1 !reset_in_n |=> stateQ == ext_bus_pkg::ST_RESET)
        else $error("reset entry latency wrong");
    chk_strobe_exclusive: assert property (
        $onehot0({!fetchN_q, !dataReadStrobe_n, !(pWriteN_q && tWriteN_q)}))
        else $error("more than one strobe low");
    chk_port_address: assert property (
        (!pReadN_q || !pWriteN_q) |-> addr_q == {13'h0000, port_q})
        else $error("port number not on low address lines");
    chk_port_upper_low: assert property (
        (!pReadN_q || !pWriteN_q) |-> addr_q[15:3] == 13'h0000)
        else $error("upper address not low on port cycle");
    chk_data_drive: assert property (
        oeB_q == (pWriteN_q && tWriteN_q))
        else $error("data bus driven outside write strobe");
    chk_read_strobe_only: assert property (
        !pReadN_q |-> ($past(stateD) == ext_bus_pkg::ST_PORT_IN && fetchN_q && tWriteN_q))
        else $error("port read strobe outside port input");
    chk_write_strobe_only: assert property (
        (stateQ == ext_bus_pkg::ST_PORT_OUT) == !pWriteN_q)
        else $error("port write strobe mismatch");
    chk_table_strobe_only: assert property (
        (stateQ == ext_bus_pkg::ST_TABLE_WR) == !tWriteN_q)
        else $error("table write strobe mismatch");
    chk_fetch_strobe_pc: assert property (
        (stateQ == ext_bus_pkg::ST_FETCH) |-> (!fetchN_q && addr_q == pc_q))
        else $error("fetch without strobe at pc");
    chk_table_sequence: assert property (
        (stateQ == ext_bus_pkg::ST_DUMMY && resetSyncB_q) |=>
            (!tWriteN_q && addr_q == tblAddr_q) ##1 (!fetchN_q || inReset))
        else $error("table write sequence broken");
    cov_table_write: cover property (
        stateQ == ext_bus_pkg::ST_DUMMY ##1 !tWriteN_q ##1 !fetchN_q);
    cov_port_in_data: cover property (!pReadN_q ##3 portV_q);
    cov_reset_resume: cover property ($rose(resetSyncB_q) ##2 ready_q ##1 !fetchN_q);
endmodule

`default_nettype wire

// [verilog/ext_bus_pkg.sv]
package ext_bus_pkg;

    // ==========================================================
    // Widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int PORT_W = 3;
    localparam int UPPER_W = ADDR_W - PORT_W;

    // ==========================================================
    // Values after reset
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;
    localparam logic [ADDR_W-1:0] PC_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
    localparam logic [PORT_W-1:0] PORT_RESET = 3'h0;
    localparam logic [UPPER_W-1:0] UPPER_ZERO = 13'h0000;

    // ==========================================================
    // Cycle counts
    localparam int MIN_RESET_CYCLES = 5;
    localparam int RESUME_CYCLES = 1;
    localparam int SYNC_STAGES = 2;

    // ==========================================================
    // Operations the core may request
    typedef enum logic [1:0] {
        OP_FETCH,
        OP_PORT_IN,
        OP_PORT_OUT,
        OP_TABLE_WRITE
    } op_t;

    // Bus sequencer states
    typedef enum logic [2:0] {
        ST_RESET,
        ST_RESUME,
        ST_IDLE,
        ST_FETCH,
        ST_PORT_IN,
        ST_PORT_OUT,
        ST_DUMMY,
        ST_TABLE_WR
    } state_t;

endpackage
